// File: design/nps_defs.svh
/*
  Constants of the NAND page command sequencer host: register offsets,
  command codes, status field positions and timing counts.
  Assumes a 20 MHz hclk and an 8-bit asynchronous NAND part on the pins.
*/
// How it works
// RULE_01 - Page read is 00h, five address cycles, then 30h.
// RULE_02 - After power-up 00h counts as latched; five addresses plus 30h suffice.
// RULE_03 - Array load of 2,112 bytes finishes within 40 us, busy shown meanwhile.
// RULE_04 - Each output strobe falling edge gives the next byte; cycle may be 25 ns.
// RULE_05 - Random data output plus new column redirects output, repeatable within page.
// RULE_06 - At most 4 partial programs on one page between erases; the host counts them only for the latest programmed page.
// RULE_07 - Program is 80h, five addresses, up to 2,112 bytes, then 10h.
// RULE_08 - 85h with new column during loading continues loading there, repeatable.
// RULE_09 - A 10h without a preceding data input sequence is ignored.
// RULE_10 - While programming only status read and reset are accepted.
// RULE_11 - End of program shows on ready/busy and status bit 6.
// RULE_12 - Verify flags only bits that failed to go from one to zero.
// RULE_13 - Pages of a block are programmed in rising address order; the host checks only against the last programmed page.
// RULE_14 - 35h with source page loads whole 2,112-byte page, still readable.
// RULE_15 - Copy-back program starts with 85h and destination; begins after 10h.
// RULE_16 - During copy-back 85h plus new column may modify buffered data.
// RULE_17 - Copy-back source and destination lie in the same plane.
// RULE_18 - After 70h or F1h status appears on the later falling edge.
// RULE_19 - Status output tracks live state without toggling strobes.
// RULE_20 - Status mode lasts until next command; write 00h to resume data.
// RULE_21 - 70h byte: bit 0 fail, bit 6 ready, bit 7 unprotected.
// RULE_22 - F1h byte: bits 0..2 chip, plane 0, plane 1 fail; bits 6, 7 as 70h.
// RULE_23 - FFh aborts operations, clears command state; status C0h; repeat accepted.
// RULE_24 - Ready/busy goes low on program, erase or read start; high when done.
// RULE_25 - With chip select low, command or address latch select marks the byte.
`ifndef NPS_DEFS_SVH
`define NPS_DEFS_SVH

`define NPS_OFF_CMD 8'h00
`define NPS_OFF_COL 8'h04
`define NPS_OFF_ROW 8'h08
`define NPS_OFF_WDATA 8'h0C
`define NPS_OFF_STATUS 8'h10
`define NPS_OFF_CTRL 8'h14

`define NPS_CMD_READ1 8'h00
`define NPS_CMD_READ2 8'h30
`define NPS_CMD_CB_READ2 8'h35
`define NPS_CMD_PROG1 8'h80
`define NPS_CMD_RAND_IN 8'h85
`define NPS_CMD_CONFIRM 8'h10
`define NPS_CMD_RAND_OUT1 8'h05
`define NPS_CMD_RAND_OUT2 8'hE0
`define NPS_CMD_STAT 8'h70
`define NPS_CMD_STAT2 8'hF1
`define NPS_CMD_RESET 8'hFF

// Status register clear bits (write one)
`define NPS_ST_REFUSED 2
`define NPS_ST_LATE 3
// Control register bits
`define NPS_CTRL_WP 0
`define NPS_CTRL_FORGET 1
`define NPS_CTRL_RESET 1'h0

`define NPS_CLK_NS 50
`define NPS_T_CYCLE_NS 25
`define NPS_STROBE_HIGH_CYC ((`NPS_T_CYCLE_NS + `NPS_CLK_NS - 1) / `NPS_CLK_NS)
`define NPS_STROBE_LOW_CYC 5
`define NPS_T_ARRAY_LOAD_US 40
`define NPS_ARRAY_LOAD_CYC ((`NPS_T_ARRAY_LOAD_US * 1000) / `NPS_CLK_NS)
`define NPS_RB_GUARD_CYC 8
`define NPS_PARTIAL_MAX 4
`define NPS_PLANE_BIT 6
`define NPS_PAGE_BITS 6

`endif

// File: design/nps_pkg.sv
/*
  Types of the NAND page command sequencer host: operations, engine
  states, the pin bundle and a decoded cycle sequence.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package nps_pkg;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_READ = 4'h1, OP_CB_READ = 4'h2, OP_PROG = 4'h3,
    OP_CB_PROG = 4'h4, OP_CONFIRM = 4'h5, OP_RAND_OUT = 4'h6, OP_RAND_IN = 4'h7,
    OP_STAT = 4'h8, OP_STAT2 = 4'h9, OP_RESET = 4'hA, OP_RD = 4'hB,
    OP_WR = 4'hC, OP_RESUME = 4'hD
  } nps_op_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_CMD1 = 7'h02, ST_ADDR = 7'h04, ST_CMD2 = 7'h08,
    ST_WDAT = 7'h10, ST_RDAT = 7'h20, ST_WAIT = 7'h40
  } nps_state_t;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic output_strobe_n;
    logic wp_n;
    logic io_oe;
    logic [7:0] io_out;
  } nps_pins_t;

  typedef struct packed {
    logic cmd1_en;
    logic [7:0] cmd1;
    logic [2:0] naddr;
    logic cmd2_en;
    logic [7:0] cmd2;
    logic wt;
    logic rd;
    logic wr;
  } nps_seq_t;
endpackage

// File: design/nps_host.sv
/*
  Host controller for an 8-bit asynchronous NAND flash: an AHB-Lite slave
  takes orders and an engine plays them out as command, address and data
  cycles on the pins. Assumes one word-wide AHB master and one NAND part
  whose ready/busy pin has an external pull-up.
*/
// Decided for this implementation: the AHB-Lite slave port and the register offsets.
`include "nps_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module nps_host #(
  parameter int PART_MAX = `NPS_PARTIAL_MAX
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] io_in,
  input wire logic rb,
  output nps_pkg::nps_pins_t pins
);
  import nps_pkg::*;

  localparam logic [2:0] PH_LOW = 3'(`NPS_STROBE_LOW_CYC);
  localparam logic [2:0] PH_LAST = 3'(`NPS_STROBE_LOW_CYC + `NPS_STROBE_HIGH_CYC);
  localparam logic [15:0] LOAD_CYC = 16'(`NPS_ARRAY_LOAD_CYC);
  localparam logic [15:0] GUARD_CYC = 16'(`NPS_RB_GUARD_CYC);
  localparam logic [2:0] PART_CAP = 3'(PART_MAX);

  // Cycle list of each operation
  function automatic nps_seq_t dec(input nps_op_t o);
    nps_seq_t s;
    s = '0;
    case (o)
      OP_READ: s = {1'b1, `NPS_CMD_READ1, 3'h5, 1'b1, `NPS_CMD_READ2, 3'b100};
      // Whole source page into the device buffer, see RULE_14
      OP_CB_READ: s = {1'b1, `NPS_CMD_READ1, 3'h5, 1'b1, `NPS_CMD_CB_READ2, 3'b100};
      OP_PROG: s = {1'b1, `NPS_CMD_PROG1, 3'h5, 1'b0, 8'h00, 3'b000};
      // Destination only; programming waits for the confirm, see RULE_15
      OP_CB_PROG: s = {1'b1, `NPS_CMD_RAND_IN, 3'h5, 1'b0, 8'h00, 3'b000};
      OP_CONFIRM: s = {1'b1, `NPS_CMD_CONFIRM, 3'h0, 1'b0, 8'h00, 3'b100};
      OP_RAND_OUT: s = {1'b1, `NPS_CMD_RAND_OUT1, 3'h2, 1'b1, `NPS_CMD_RAND_OUT2, 3'b000};
      OP_RAND_IN: s = {1'b1, `NPS_CMD_RAND_IN, 3'h2, 1'b0, 8'h00, 3'b000};
      OP_STAT: s = {1'b1, `NPS_CMD_STAT, 3'h0, 1'b0, 8'h00, 3'b010};
      OP_STAT2: s = {1'b1, `NPS_CMD_STAT2, 3'h0, 1'b0, 8'h00, 3'b010};
      OP_RESET: s = {1'b1, `NPS_CMD_RESET, 3'h0, 1'b0, 8'h00, 3'b100};
      OP_RD: s = {1'b0, 8'h00, 3'h0, 1'b0, 8'h00, 3'b010};
      OP_WR: s = {1'b0, 8'h00, 3'h0, 1'b0, 8'h00, 3'b001};
      OP_RESUME: s = {1'b1, `NPS_CMD_READ1, 3'h0, 1'b0, 8'h00, 3'b000};
      default: s = '0;
    endcase
    return s;
  endfunction

  // First state not yet done at a given level of the sequence
  function automatic nps_state_t after(input nps_seq_t s, input logic [1:0] lvl);
    if (lvl == 2'h0 && s.cmd1_en) return ST_CMD1;
    if (lvl <= 2'h1 && s.naddr != 3'h0) return ST_ADDR;
    if (lvl <= 2'h2 && s.cmd2_en) return ST_CMD2;
    if (s.wr) return ST_WDAT;
    if (s.rd) return ST_RDAT;
    if (s.wt) return ST_WAIT;
    return ST_IDLE;
  endfunction

  // Pin inputs: three stages, a change counts when stages two and three agree
  logic [8:0] s1, s2, s3, filt, next_filt;
  logic rb_f;
  logic [7:0] io_f;
  always_comb begin
    next_filt = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1 <= 9'h1FF;
      s2 <= 9'h1FF;
      s3 <= 9'h1FF;
      filt <= 9'h1FF;
    end else begin
      s1 <= {rb, io_in};
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
    end
  end
  assign rb_f = filt[8];
  assign io_f = filt[7:0];

  // Bus slave and engine state
  logic dp_we, next_dp_we;
  logic [7:0] dp_addr, next_dp_addr;
  logic [31:0] next_hrdata;
  logic [11:0] col, next_col;
  logic [16:0] row, next_row, last_row, next_last_row, src_row, next_src_row;
  logic [7:0] wdata, next_wdata, rdata, next_rdata;
  logic ctrl_wp, next_ctrl_wp;
  nps_state_t st, next_st;
  nps_op_t op, next_op, req_op;
  nps_seq_t seq, next_seq;
  logic [2:0] ph, next_ph, aidx, next_aidx, part_cnt, next_part_cnt;
  logic [15:0] wcnt, next_wcnt;
  logic refused, next_refused, late, next_late, loading, next_loading;
  logic stat_mode, next_stat_mode, last_valid, next_last_valid;
  logic src_valid, next_src_valid;
  nps_pins_t next_pins;
  logic accept, wr_cmd, start, bad, same_row, same_blk, step_end, low;
  logic [7:0] abyte;

  // Read mux sampled in the address phase, so hrdata is a flop
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    case (a)
      `NPS_OFF_CMD: return {28'h0000000, op};
      `NPS_OFF_COL: return {20'h00000, col};
      `NPS_OFF_ROW: return {15'h0000, row};
      `NPS_OFF_WDATA: return {24'h000000, wdata};
      `NPS_OFF_STATUS: return {13'h0000, part_cnt, rdata, 2'h0, stat_mode, loading,
                               late, refused, rb_f, st != ST_IDLE};
      `NPS_OFF_CTRL: return {31'h00000000, ctrl_wp};
      default: return 32'h00000000;
    endcase
  endfunction

  // Legality of a new order; refusals are flagged, never queued
  always_comb begin
    accept = hsel && htrans[1] && hready && hsize == 3'h2;
    wr_cmd = dp_we && dp_addr == `NPS_OFF_CMD;
    req_op = nps_op_t'(hwdata[3:0]);
    same_row = last_valid && row == last_row;
    same_blk = last_valid && row[16:`NPS_PAGE_BITS] == last_row[16:`NPS_PAGE_BITS];
    bad = 1'b0;
    if (req_op == OP_NONE || req_op > OP_RESUME) bad = 1'b1;
    // Only status, reset and data reads while the part is busy, see RULE_10
    if (!rb_f && !(req_op inside {OP_STAT, OP_STAT2, OP_RESET, OP_RD})) bad = 1'b1;
    if (req_op == OP_PROG || req_op == OP_CB_PROG) begin
      // Rising page order within a block, see RULE_13
      if (same_blk && row[`NPS_PAGE_BITS-1:0] < last_row[`NPS_PAGE_BITS-1:0]) bad = 1'b1;
      // Partial program cap; only the latest page is tracked, see RULE_06
      if (same_row && part_cnt >= PART_CAP) bad = 1'b1;
    end
    // Copy-back needs a source read in the same plane, see RULE_17
    if (req_op == OP_CB_PROG && (!src_valid ||
        row[`NPS_PLANE_BIT] != src_row[`NPS_PLANE_BIT])) bad = 1'b1;
    // Confirm only after a data input sequence, see RULE_07
    if (req_op == OP_CONFIRM && !loading) bad = 1'b1;
    start = wr_cmd && st == ST_IDLE && !bad;
  end

  // Next values of bus, software registers and engine
  always_comb begin
    next_dp_we = accept && hwrite;
    next_dp_addr = haddr[7:0];
    next_hrdata = (accept && !hwrite) ? rd_mux(haddr[7:0]) : hrdata;
    next_col = col;
    next_row = row;
    next_wdata = wdata;
    next_ctrl_wp = ctrl_wp;
    next_st = st;
    next_op = op;
    next_seq = seq;
    next_ph = ph;
    next_aidx = aidx;
    next_wcnt = wcnt;
    next_rdata = rdata;
    next_loading = loading;
    next_stat_mode = stat_mode;
    next_last_row = last_row;
    next_last_valid = last_valid;
    next_part_cnt = part_cnt;
    next_src_row = src_row;
    next_src_valid = src_valid;
    next_late = late;
    next_refused = refused;
    step_end = ph == PH_LAST;
    if (dp_we && dp_addr == `NPS_OFF_COL) next_col = hwdata[11:0];
    if (dp_we && dp_addr == `NPS_OFF_ROW) next_row = hwdata[16:0];
    if (dp_we && dp_addr == `NPS_OFF_WDATA) next_wdata = hwdata[7:0];
    if (dp_we && dp_addr == `NPS_OFF_CTRL) begin
      next_ctrl_wp = hwdata[`NPS_CTRL_WP];
      if (hwdata[`NPS_CTRL_FORGET]) next_last_valid = 1'b0;
    end
    if (dp_we && dp_addr == `NPS_OFF_STATUS) begin
      next_refused = refused & ~hwdata[`NPS_ST_REFUSED];
      next_late = late & ~hwdata[`NPS_ST_LATE];
    end
    // Set wins over a clear in the same cycle
    if (wr_cmd && !start) next_refused = 1'b1;
    case (st)
      ST_IDLE: begin
        if (start) begin
          next_op = req_op;
          next_seq = dec(req_op);
          next_st = after(dec(req_op), 2'h0);
          next_ph = 3'h0;
          next_aidx = 3'h0;
          next_wcnt = 16'h0000;
          if (dec(req_op).cmd1_en) next_stat_mode = req_op == OP_STAT || req_op == OP_STAT2;
          if (req_op == OP_PROG || req_op == OP_CB_PROG) begin
            next_loading = 1'b1;
            next_part_cnt = same_row ? part_cnt + 3'h1 : 3'h1;
            next_last_row = row;
            next_last_valid = 1'b1;
          end
          if (req_op == OP_CB_READ) begin
            next_src_row = row;
            next_src_valid = 1'b1;
          end
          if (req_op == OP_RESET) next_loading = 1'b0;
        end
      end
      ST_CMD1: begin
        next_ph = step_end ? 3'h0 : ph + 3'h1;
        if (step_end) begin
          next_st = after(seq, 2'h1);
          if (seq.cmd1 == `NPS_CMD_CONFIRM) next_loading = 1'b0;
        end
      end
      ST_ADDR: begin
        next_ph = step_end ? 3'h0 : ph + 3'h1;
        if (step_end) begin
          next_aidx = aidx + 3'h1;
          if (aidx == seq.naddr - 3'h1) begin
            next_aidx = 3'h0;
            next_st = after(seq, 2'h2);
          end
        end
      end
      ST_CMD2: begin
        next_ph = step_end ? 3'h0 : ph + 3'h1;
        if (step_end) next_st = after(seq, 2'h3);
      end
      ST_WDAT: begin
        next_ph = step_end ? 3'h0 : ph + 3'h1;
        if (step_end) next_st = ST_IDLE;
      end
      ST_RDAT: begin
        // Byte taken as the strobe rises, see RULE_04
        next_ph = step_end ? 3'h0 : ph + 3'h1;
        if (step_end) begin
          next_rdata = io_f;
          next_st = ST_IDLE;
        end
      end
      ST_WAIT: begin
        // Guard covers the busy delay before ready is trusted, see RULE_03
        if (wcnt != 16'hFFFF) next_wcnt = wcnt + 16'h0001;
        if (wcnt == LOAD_CYC && (op == OP_READ || op == OP_CB_READ)) next_late = 1'b1;
        if (wcnt >= GUARD_CYC && rb_f) next_st = ST_IDLE;
      end
      default: next_st = ST_IDLE;
    endcase
  end

  // Pin levels from the current step; registered, so they lag one cycle
  always_comb begin
    low = ph != 3'h0 && ph <= PH_LOW;
    case (aidx)
      3'h0: abyte = col[7:0];
      3'h1: abyte = {4'h0, col[11:8]};
      3'h2: abyte = row[7:0];
      3'h3: abyte = row[15:8];
      default: abyte = {7'h00, row[16]};
    endcase
    next_pins = '0;
    next_pins.ce_n = st == ST_IDLE;
    next_pins.we_n = 1'b1;
    next_pins.output_strobe_n = 1'b1;
    next_pins.wp_n = ctrl_wp;
    case (st)
      // Write strobe framed by the latch selects, see RULE_25
      ST_CMD1, ST_CMD2: begin
        next_pins.cle = 1'b1;
        next_pins.io_oe = 1'b1;
        next_pins.io_out = st == ST_CMD1 ? seq.cmd1 : seq.cmd2;
        next_pins.we_n = !low;
      end
      ST_ADDR: begin
        next_pins.ale = 1'b1;
        next_pins.io_oe = 1'b1;
        next_pins.io_out = abyte;
        next_pins.we_n = !low;
      end
      ST_WDAT: begin
        next_pins.io_oe = 1'b1;
        next_pins.io_out = wdata;
        next_pins.we_n = !low;
      end
      ST_RDAT: next_pins.output_strobe_n = !low;
      default: next_pins.ce_n = st == ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_we <= 1'b0;
      dp_addr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      col <= 12'h000;
      row <= 17'h00000;
      wdata <= 8'h00;
      ctrl_wp <= `NPS_CTRL_RESET;
      st <= ST_IDLE;
      op <= OP_NONE;
      seq <= '0;
      ph <= 3'h0;
      aidx <= 3'h0;
      wcnt <= 16'h0000;
      rdata <= 8'h00;
      loading <= 1'b0;
      stat_mode <= 1'b0;
      last_row <= 17'h00000;
      last_valid <= 1'b0;
      part_cnt <= 3'h0;
      src_row <= 17'h00000;
      src_valid <= 1'b0;
      late <= 1'b0;
      refused <= 1'b0;
      pins <= {1'b1, 2'h0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00};
    end else begin
      dp_we <= next_dp_we;
      dp_addr <= next_dp_addr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      col <= next_col;
      row <= next_row;
      wdata <= next_wdata;
      ctrl_wp <= next_ctrl_wp;
      st <= next_st;
      op <= next_op;
      seq <= next_seq;
      ph <= next_ph;
      aidx <= next_aidx;
      wcnt <= next_wcnt;
      rdata <= next_rdata;
      loading <= next_loading;
      stat_mode <= next_stat_mode;
      last_row <= next_last_row;
      last_valid <= next_last_valid;
      part_cnt <= next_part_cnt;
      src_row <= next_src_row;
      src_valid <= next_src_valid;
      late <= next_late;
      refused <= next_refused;
      pins <= next_pins;
    end
  end

  // Checks on the pin sequences and the engine's order rules
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_strobe_low;
    (!pins.output_strobe_n)[*5] ##1 pins.output_strobe_n;
  endsequence
  sequence s_resume_cmd;
    pins.cle && pins.io_out == `NPS_CMD_READ1;
  endsequence
  a_cmd_latch_sel: assert property ((st == ST_CMD1 && ph == 3'h1) |=> // see RULE_25
    (pins.cle && !pins.ale && !pins.ce_n && !pins.we_n)) else $error("bad command latch");
  a_read_confirm: assert property ((st == ST_CMD2 && op == OP_READ) |=> // see RULE_01
    pins.io_out == `NPS_CMD_READ2) else $error("read confirm not 30h");
  a_five_addr: assert property (($rose(st == ST_CMD2) && op == OP_READ) |-> // see RULE_01
    $past(aidx) == 3'h4) else $error("read without five address cycles");
  a_wait_ready: assert property ($fell(st == ST_WAIT) |-> // see RULE_03
    (rb_f && wcnt >= GUARD_CYC)) else $error("wait ended while busy");
  a_strobe_width: assert property ($fell(pins.output_strobe_n) |-> s_strobe_low) // see RULE_04
    else $error("output strobe width wrong");
  a_rand_out_col: assert property ((st == ST_CMD2 && op == OP_RAND_OUT) |-> // see RULE_05
    seq.naddr == 3'h2 ##1 pins.io_out == `NPS_CMD_RAND_OUT2) else $error("bad random output");
  a_partial_cap: assert property (part_cnt <= PART_CAP) // see RULE_06
    else $error("too many partial programs");
  a_confirm_loaded: assert property ((st == ST_CMD1 && seq.cmd1 == `NPS_CMD_CONFIRM) |-> // see RULE_07
    loading) else $error("confirm without data input");
  a_page_order: assert property ((start && op != OP_PROG && req_op == OP_PROG && same_blk) // see RULE_13
    |=> row[5:0] >= $past(last_row[5:0])) else $error("page order broken");
  a_plane_same: assert property ((st == ST_CMD1 && op == OP_CB_PROG) |-> // see RULE_17
    (src_valid && last_row[`NPS_PLANE_BIT] == src_row[`NPS_PLANE_BIT]))
    else $error("copy-back across planes");
  a_resume_read: assert property ((st == ST_CMD1 && op == OP_RESUME) |=> s_resume_cmd) // see RULE_20
    else $error("resume did not send 00h");
endmodule
`default_nettype wire

// File: tb/nps_nand_model.sv
/*
  Behavioural NAND device model: array, page buffer, command decoder, status.
  Assumes the bench resolves the I/O wire and feeds it back on io.
*/
`timescale 1ns/100ps
`default_nettype none
module nps_nand_model #(
  parameter int LOAD_NS = 3000,
  parameter int PROG_NS = 6000
) (
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic output_strobe_n,
  input wire logic wp_n,
  input wire logic [7:0] io,
  output logic [7:0] dout,
  output logic dev_oe,
  output logic rb
);
  logic [7:0] mem [int];
  logic [7:0] pbuf [0:2111];
  logic [7:0] ab [0:4];
  logic [7:0] lcmd = 8'h00; // Power-up read setup latched
  logic [7:0] dq = 8'h00;
  logic busy = 1'b0;
  logic smode = 1'b0;
  logic load = 1'b0;
  int col = 0;
  int row = 0;
  int na = 0;
  int gen = 0;
  // Status is live, never a snapshot; fail bits stay clear
  assign dout = smode ? {wp_n, ~busy, 6'h00} : dq;
  assign dev_oe = ~ce_n & ~output_strobe_n; // Later of both falls
  assign rb = ~busy;

  function automatic logic [7:0] rdm(input int k);
    return mem.exists(k) ? mem[k] : 8'hFF;
  endfunction

  // A newer busy period cancels the older one, so reset aborts
  task automatic go_busy(input int d, input bit wr);
    int g;
    gen++;
    g = gen;
    busy = 1'b1;
    fork
      begin
        #(d);
        if (g == gen) begin
          if (wr) foreach (pbuf[i]) mem[row * 4096 + i] = rdm(row * 4096 + i) & pbuf[i];
          busy = 1'b0;
        end
      end
    join_none
  endtask

  // Latch on the input strobe rise
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      if (!busy || io == 8'h70 || io == 8'hF1 || io == 8'hFF) begin
        case (io)
          8'h00: begin
            na = 0;
            smode = 1'b0;
          end
          8'h30, 8'h35: if (lcmd == 8'h00 && na == 5) begin
            foreach (pbuf[i]) pbuf[i] = rdm(row * 4096 + i);
            go_busy(LOAD_NS, 1'b0);
          end
          8'h80: begin
            foreach (pbuf[i]) pbuf[i] = 8'hFF;
            na = 0;
            load = 1'b1;
          end
          8'h85: begin
            na = 0;
            load = 1'b1;
          end
          8'h10: if (load) begin
            load = 1'b0;
            smode = 1'b1;
            go_busy(PROG_NS, 1'b1);
          end
          8'h05: na = 0;
          8'hE0: smode = 1'b0;
          8'h70, 8'hF1: smode = 1'b1;
          8'hFF: begin
            load = 1'b0;
            go_busy(500, 1'b0);
          end
          default: ;
        endcase
        lcmd = io;
      end
    end else if (!ce_n && ale && !busy) begin
      if (na < 5) ab[na] = io;
      na++;
      if (na == 2) col = int'({ab[1][3:0], ab[0]});
      if (na == 5) row = int'({ab[4][0], ab[3], ab[2]});
    end else if (!ce_n && load && !busy) begin
      pbuf[col % 2112] = io;
      col++;
    end
  end

  // Next byte on each output strobe fall
  always @(negedge output_strobe_n) begin
    if (!ce_n && !smode && !busy) begin
      dq = pbuf[col % 2112];
      col++;
    end
  end
endmodule
`default_nettype wire

// File: tb/test_nps_host.sv
/*
  Testbench of the NAND host: register tasks over AHB-Lite, a device model
  on the pins, tests as call sequences. Assumes the model in its own file.
*/
`include "nps_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module test_nps_host;
  import nps_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [7:0] io_wire;
  logic [7:0] io_last = 8'h00;
  logic [7:0] dout;
  logic dev_oe;
  logic rb;
  nps_pins_t pins;
  int err_count = 0;
  int cmp_count = 0;

  // Floating bus shows a changing pattern, not a stale byte
  assign io_wire = pins.io_oe ? pins.io_out : (dev_oe ? dout : ~io_last);
  always @(posedge hclk) io_last <= io_wire;
  initial forever #25 hclk = ~hclk;

  nps_host i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .io_in(io_wire), .rb(rb), .pins(pins));
  nps_nand_model i_nand (.ce_n(pins.ce_n), .cle(pins.cle), .ale(pins.ale),
    .we_n(pins.we_n), .output_strobe_n(pins.output_strobe_n), .wp_n(pins.wp_n), .io(io_wire),
    .dout(dout), .dev_oe(dev_oe), .rb(rb));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One single transfer; waits on hready in both phases
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h00000000, x);
    chk(x & m, e);
  endtask

  // Order, then poll the busy flag; the watchdog bounds the wait
  task automatic op(input logic [3:0] c);
    logic [31:0] x;
    wr(`NPS_OFF_CMD, {28'h0000000, c});
    repeat (3) @(posedge hclk);
    do ahb(1'b0, `NPS_OFF_STATUS, 32'h00000000, x); while (x[0] !== 1'b0);
  endtask

  task automatic bchk(input logic [3:0] c, input logic [7:0] e);
    op(c);
    rd_chk(`NPS_OFF_STATUS, 32'h0000FF00, {16'h0000, e, 8'h00});
  endtask

  task automatic at(input logic [31:0] c, input logic [31:0] r);
    wr(`NPS_OFF_COL, c);
    wr(`NPS_OFF_ROW, r);
  endtask

  task automatic wb(input logic [7:0] d);
    wr(`NPS_OFF_WDATA, {24'h000000, d});
    op(4'hC);
  endtask

  task automatic mchk(input int k, input logic [7:0] e);
    chk({24'h000000, i_nand.rdm(k)}, {24'h000000, e});
  endtask

  task automatic refused(input logic [31:0] e);
    rd_chk(`NPS_OFF_STATUS, 32'h00000004, e);
    wr(`NPS_OFF_STATUS, 32'h00000004);
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #3000000;
    err_count++;
    $display("Error %0t watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    repeat (16) @(posedge hclk);
    chk({24'h0, pins.ce_n, pins.wp_n, pins.io_oe, hresp, 4'h0}, 32'h00000080);
    hresetn <= 1'b1;
    wr(`NPS_OFF_CTRL, 32'h00000001);
    op(4'hA);
    op(4'hA);
    bchk(4'h8, 8'hC0);
    bchk(4'h9, 8'hC0);
    $display("Test reset and status done");
    at(0, 3);
    op(4'h3);
    wb(8'hA5);
    wb(8'h3C);
    at(10, 3);
    op(4'h7);
    wb(8'h5A);
    op(4'h5);
    bchk(4'hB, 8'hC0);
    mchk(3 * 4096, 8'hA5);
    mchk(3 * 4096 + 1, 8'h3C);
    mchk(3 * 4096 + 2, 8'hFF);
    mchk(3 * 4096 + 10, 8'h5A);
    $display("Test program done");
    at(1, 3);
    op(4'h1);
    bchk(4'hB, 8'h3C);
    bchk(4'hB, 8'hFF);
    at(10, 3);
    op(4'h6);
    bchk(4'hB, 8'h5A);
    at(0, 3);
    op(4'h6);
    bchk(4'h8, 8'hC0);
    op(4'hD);
    bchk(4'hB, 8'hA5);
    rd_chk(`NPS_OFF_STATUS, 32'h00000008, 32'h00000000);
    $display("Test read done");
    op(4'h5);
    refused(32'h00000004);
    rd_chk(8'h20, 32'hFFFFFFFF, 32'h00000000);
    $display("Test refusal done");
    at(0, 3);
    op(4'h2);
    bchk(4'hB, 8'hA5);
    at(1, 32'h43);
    op(4'h4);
    refused(32'h00000004);
    at(1, 5);
    op(4'h4);
    wb(8'h0F);
    op(4'h5);
    mchk(5 * 4096, 8'hA5);
    mchk(5 * 4096 + 1, 8'h0F);
    mchk(5 * 4096 + 10, 8'h5A);
    $display("Test copy-back done");
    for (int k = 0; k < 4; k++) begin
      at(k, 7);
      op(4'h3);
      wb(8'hF0 | 8'(k));
      op(4'h5);
    end
    mchk(7 * 4096 + 3, 8'hF3);
    rd_chk(`NPS_OFF_STATUS, 32'h00070000, 32'h00040000);
    at(4, 7);
    op(4'h3);
    refused(32'h00000004);
    at(0, 6);
    op(4'h3);
    refused(32'h00000004);
    $display("Test partial and order done");
    report_and_stop();
  end
endmodule
`default_nettype wire
